// file: dcs_bkpt.sv
// breakpoint match register and force/tag compare unit
`timescale 1ns/1ns
`default_nettype none
module dcs_bkpt (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // control side
  dcs_bp_if.unit   bp
);
  import dcs_pkg::*;

  logic [BP_W-1:0] match_addr;
  logic            force_pending;
  logic            tag_opcode;
  logic [BP_W-1:0] next_match_addr;
  logic            next_force_pending;
  logic            next_tag_opcode;
  logic            hit;

  always_comb begin
    hit                = bp.cpu_addr_valid && (bp.cpu_addr == match_addr);
    next_match_addr    = bp.wr ? bp.wdata : match_addr;
    next_force_pending = force_pending;
    if (!bp.enable) begin
      next_force_pending = 1'b0;
    end else if (hit && bp.force_mode) begin
      next_force_pending = 1'b1;
    end else if (bp.consume) begin
      next_force_pending = 1'b0;
    end
    next_tag_opcode = bp.enable && !bp.force_mode && hit && bp.cpu_fetch;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      match_addr    <= BP_RESET;
      force_pending <= 1'b0;
      tag_opcode    <= 1'b0;
    end else begin
      match_addr    <= next_match_addr;
      force_pending <= next_force_pending;
      tag_opcode    <= next_tag_opcode;
    end
  end

  assign bp.match_addr    = match_addr;
  assign bp.force_pending = force_pending;
  assign bp.tag_opcode    = tag_opcode;

  AST_BKPT_DISABLED: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !bp.enable |=> !force_pending && !tag_opcode)
    else $error("breakpoint requested while disabled");
  AST_TAG_ON_FETCH: assert property (@(posedge ref_clk) disable iff (!reset_n)
    bp.enable && !bp.force_mode && bp.cpu_fetch && bp.cpu_addr_valid && bp.cpu_addr == match_addr
    |=> tag_opcode)
    else $error("matching opcode fetch not tagged");
  AST_FORCE_ARM: assert property (@(posedge ref_clk) disable iff (!reset_n)
    bp.enable && bp.force_mode && bp.cpu_addr_valid && bp.cpu_addr == match_addr |=> force_pending)
    else $error("forced breakpoint not armed on match");
endmodule : dcs_bkpt
`default_nettype wire

// file: dcs_host_model.sv
// debug host model issuing serial commands to the register block
`timescale 1ns/1ns
`default_nettype none
module dcs_host_model (
  // clock
  input  wire logic        ref_clk,
  // answers from the block
  input  wire logic        rsp_valid,
  input  wire logic [15:0] rsp_data,
  // commands to the block
  output var  logic        cmd_valid,
  output var  logic [7:0]  cmd_code,
  output var  logic [15:0] cmd_wdata
);
  import dcs_pkg::*;

  initial begin
    cmd_valid = 1'b0;
    cmd_code  = 8'h00;
    cmd_wdata = 16'h0000;
  end

  // one command after gap idle cycles; returns at the taking edge
  task automatic send(input logic [7:0] code, input logic [15:0] data, input int gap);
    repeat (gap) @(posedge ref_clk);
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_code  <= code;
    cmd_wdata <= data;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    // released lines must not keep showing the last value
    cmd_code  <= ~code;
    cmd_wdata <= ~data;
  endtask : send

  // read command; answer is {rsp_valid, rsp_data} one cycle after taking
  task automatic read(input logic [7:0] code, output logic [16:0] ans);
    send(code, 16'h0000, 0);
    @(posedge ref_clk);
    ans = {rsp_valid, rsp_data};
  endtask : read

  // control byte write; permit is set early in a session and after resets
  task automatic write_ctl(input logic [7:0] ctl, input int gap);
    send(CMD_WRITE_CONTROL, {8'h00, ctl}, gap);
  endtask : write_ctl

  // force background, then confirm the active bit before anything else
  task automatic enter_bg(output logic [16:0] ans);
    send(CMD_BACKGROUND, 16'h0000, 0);
    read(CMD_READ_STATUS, ans);
  endtask : enter_bg
endmodule : dcs_host_model
`default_nettype wire

// file: dcs_if.sv
// interfaces between the register block and its breakpoint and status units
`timescale 1ns/1ns
`default_nettype none
interface dcs_bp_if;
  logic        enable;
  logic        force_mode;
  logic        wr;
  logic [15:0] wdata;
  logic        consume;
  logic [15:0] cpu_addr;
  logic        cpu_addr_valid;
  logic        cpu_fetch;
  logic [15:0] match_addr;
  logic        force_pending;
  logic        tag_opcode;
  modport ctrl (output enable, force_mode, wr, wdata, consume, cpu_addr, cpu_addr_valid, cpu_fetch,
                input  match_addr, force_pending, tag_opcode);
  modport unit (input  enable, force_mode, wr, wdata, consume, cpu_addr, cpu_addr_valid, cpu_fetch,
                output match_addr, force_pending, tag_opcode);
endinterface : dcs_bp_if

interface dcs_st_if;
  logic cpu_wait_stop;
  logic active;
  logic enter_from_ws;
  logic fail;
  logic clear_fail;
  logic ws;
  logic wait_stop_fail;
  modport ctrl (output cpu_wait_stop, active, enter_from_ws, fail, clear_fail, input ws, wait_stop_fail);
  modport unit (input cpu_wait_stop, active, enter_from_ws, fail, clear_fail, output ws, wait_stop_fail);
endinterface : dcs_st_if
`default_nettype wire

// file: dcs_pkg.sv
// constants shared by the debug control/status register block
package dcs_pkg;
  localparam int unsigned SC_W = 8;
  localparam int unsigned BP_W = 16;

  // status/control bit positions
  localparam int unsigned BIT_PERMIT  = 7;
  localparam int unsigned BIT_ACTIVE  = 6;
  localparam int unsigned BIT_BKPT_EN = 5;
  localparam int unsigned BIT_FORCE   = 4;
  localparam int unsigned BIT_CLKSEL  = 3;
  localparam int unsigned BIT_WS      = 2;
  localparam int unsigned BIT_WSF     = 1;
  localparam int unsigned BIT_DVF     = 0;

  localparam logic [SC_W-1:0] SC_RESET = 8'h00;
  localparam logic [BP_W-1:0] BP_RESET = 16'h0000;
  localparam logic [BP_W-1:0] RSP_RESET = 16'h0000;

  // serial command codes seen by this block
  localparam logic [7:0] CMD_READ_STATUS   = 8'hE4;
  localparam logic [7:0] CMD_WRITE_CONTROL = 8'hC4;
  localparam logic [7:0] CMD_READ_BKPT     = 8'hE2;
  localparam logic [7:0] CMD_WRITE_BKPT    = 8'hC2;
  localparam logic [7:0] CMD_BACKGROUND    = 8'h90;
  localparam logic [7:0] CMD_GO            = 8'h08;
  localparam logic [7:0] CMD_TRACE1        = 8'h10;
  localparam logic [7:0] CMD_TAGGO         = 8'h18;

  typedef enum logic [0:0] {
    DCS_RUN  = 1'b0,
    DCS_BGND = 1'b1
  } dcs_mode_e;
endpackage : dcs_pkg

// file: dcs_regs.sv
// debug status/control and breakpoint registers reached only by serial commands
`timescale 1ns/1ns
`default_nettype none
module dcs_regs #(
  parameter int unsigned ADDR_W = dcs_pkg::BP_W
) (
  // clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     reset_n,
  // serial command decoder side
  input  wire logic                     cmd_valid,
  input  wire logic [7:0]               cmd_code,
  input  wire logic [dcs_pkg::BP_W-1:0] cmd_wdata,
  output var  logic                     rsp_valid,
  output var  logic [dcs_pkg::BP_W-1:0] rsp_data,
  // cpu side
  input  wire logic [dcs_pkg::BP_W-1:0] cpu_addr,
  input  wire logic                     cpu_addr_valid,
  input  wire logic                     cpu_opcode_fetch,
  input  wire logic                     cpu_instr_boundary,
  input  wire logic                     cpu_tag_at_queue_end,
  input  wire logic                     cpu_wait_stop,
  input  wire logic                     mem_cmd_fail_ws,
  // control and status outputs
  output var  logic                     background_active,
  output var  logic                     cpu_wake,
  output var  logic                     tag_opcode,
  output var  logic                     background_permit,
  output var  logic                     comm_clock_select,
  output var  logic                     wait_stop_status
);
  import dcs_pkg::*;

  if (ADDR_W != BP_W) begin : g_width_check
    $error("breakpoint address width must equal the command data width");
  end

  dcs_bp_if bp ();
  dcs_st_if st ();

  // control bits; no CPU address decode exists for any of them
  logic            permit;
  logic            bkpt_en;
  logic            force_sel;
  logic            clk_sel;
  dcs_mode_e       mode;
  logic            active;
  logic            wake;
  logic            rsp_v;
  logic [BP_W-1:0] rsp_d;

  logic            next_permit;
  logic            next_bkpt_en;
  logic            next_force_sel;
  logic            next_clk_sel;
  dcs_mode_e       next_mode;
  logic            next_active;
  logic            next_wake;
  logic            next_rsp_v;
  logic [BP_W-1:0] next_rsp_d;

  logic            is_rd_status;
  logic            is_wr_ctrl;
  logic            is_rd_bkpt;
  logic            is_wr_bkpt;
  logic            is_bgnd;
  logic            is_go;
  logic            enter_bgnd;
  logic [SC_W-1:0] status_byte;

  // command decode
  always_comb begin
    is_rd_status = cmd_valid && (cmd_code == CMD_READ_STATUS);
    is_wr_ctrl   = cmd_valid && (cmd_code == CMD_WRITE_CONTROL);
    is_rd_bkpt   = cmd_valid && (cmd_code == CMD_READ_BKPT);
    is_wr_bkpt   = cmd_valid && (cmd_code == CMD_WRITE_BKPT);
    is_bgnd      = cmd_valid && (cmd_code == CMD_BACKGROUND);
    is_go        = cmd_valid && ((cmd_code == CMD_GO) || (cmd_code == CMD_TRACE1) || (cmd_code == CMD_TAGGO));
  end

  // status/control byte as read by the host
  always_comb begin
    status_byte              = SC_RESET;
    status_byte[BIT_PERMIT]  = permit;
    status_byte[BIT_ACTIVE]  = active;
    status_byte[BIT_BKPT_EN] = bkpt_en;
    status_byte[BIT_FORCE]   = force_sel;
    status_byte[BIT_CLKSEL]  = clk_sel;
    status_byte[BIT_WS]      = st.ws;
    status_byte[BIT_WSF]     = st.wait_stop_fail;
    status_byte[BIT_DVF]     = 1'b0;
  end

  // writable control bits
  always_comb begin
    next_permit    = permit;
    next_bkpt_en   = bkpt_en;
    next_force_sel = force_sel;
    next_clk_sel   = clk_sel;
    if (is_wr_ctrl) begin
      if (mode != DCS_BGND) begin
        next_permit = cmd_wdata[BIT_PERMIT];
      end
      next_bkpt_en   = cmd_wdata[BIT_BKPT_EN];
      next_force_sel = cmd_wdata[BIT_FORCE];
      next_clk_sel   = cmd_wdata[BIT_CLKSEL];
      // active, ws, wsf and dvf are never taken from the write data
    end
  end

  // background mode entry and exit
  // a force left pending just before the breakpoint was disabled or
  // switched to tag mode must not fire, so the force path is gated here too
  always_comb begin
    enter_bgnd = (mode == DCS_RUN) && permit &&
                 (is_bgnd ||
                  (bkpt_en && force_sel && bp.force_pending && cpu_instr_boundary) ||
                  (bkpt_en && !force_sel && cpu_tag_at_queue_end));
    next_mode = mode;
    unique case (mode)
      DCS_RUN: begin
        if (enter_bgnd) begin
          next_mode = DCS_BGND;
        end
      end
      DCS_BGND: begin
        if (is_go) begin
          next_mode = DCS_RUN;
        end
      end
    endcase
    next_active = (next_mode == DCS_BGND);
    next_wake   = enter_bgnd && is_bgnd && cpu_wait_stop;
  end

  // read responses
  always_comb begin
    next_rsp_v = is_rd_status || is_rd_bkpt;
    next_rsp_d = rsp_d;
    if (is_rd_status) begin
      next_rsp_d = {{(BP_W-SC_W){1'b0}}, status_byte};
    end else if (is_rd_bkpt) begin
      next_rsp_d = bp.match_addr;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      permit    <= SC_RESET[BIT_PERMIT];
      bkpt_en   <= SC_RESET[BIT_BKPT_EN];
      force_sel <= SC_RESET[BIT_FORCE];
      clk_sel   <= SC_RESET[BIT_CLKSEL];
      mode      <= DCS_RUN;
      active    <= 1'b0;
      wake      <= 1'b0;
      rsp_v     <= 1'b0;
      rsp_d     <= RSP_RESET;
    end else begin
      permit    <= next_permit;
      bkpt_en   <= next_bkpt_en;
      force_sel <= next_force_sel;
      clk_sel   <= next_clk_sel;
      mode      <= next_mode;
      active    <= next_active;
      wake      <= next_wake;
      rsp_v     <= next_rsp_v;
      rsp_d     <= next_rsp_d;
    end
  end

  // breakpoint unit hookup
  assign bp.enable         = bkpt_en;
  assign bp.force_mode     = force_sel;
  assign bp.wr             = is_wr_bkpt;
  assign bp.wdata          = cmd_wdata;
  assign bp.consume        = enter_bgnd;
  assign bp.cpu_addr       = cpu_addr;
  assign bp.cpu_addr_valid = cpu_addr_valid;
  assign bp.cpu_fetch      = cpu_opcode_fetch;

  dcs_bkpt u_bkpt (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .bp      (bp.unit)
  );

  // status unit hookup
  assign st.cpu_wait_stop = cpu_wait_stop;
  assign st.active        = active;
  assign st.enter_from_ws = enter_bgnd && is_bgnd && cpu_wait_stop;
  assign st.fail          = mem_cmd_fail_ws;
  assign st.clear_fail    = is_bgnd;

  dcs_status u_status (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .st      (st.unit)
  );

  assign rsp_valid         = rsp_v;
  assign rsp_data          = rsp_d;
  assign background_active = active;
  assign cpu_wake          = wake;
  assign tag_opcode        = bp.tag_opcode;
  assign background_permit = permit;
  assign comm_clock_select = clk_sel;
  assign wait_stop_status  = st.ws;

  AST_PERMIT_LOCKED: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (mode == DCS_BGND) && is_wr_ctrl |=> permit == $past(permit))
    else $error("permit bit changed in background mode");
  AST_CLKSEL_ANYTIME: assert property (@(posedge ref_clk) disable iff (!reset_n)
    is_wr_ctrl |=> clk_sel == $past(cmd_wdata[BIT_CLKSEL]))
    else $error("clock select write lost");
  AST_NO_ENTRY_UNPERMITTED: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (mode == DCS_RUN) && !permit |=> mode == DCS_RUN)
    else $error("background entered without permit");
  AST_ACTIVE_FLAG: assert property (@(posedge ref_clk) disable iff (!reset_n)
    active == (mode == DCS_BGND))
    else $error("active bit disagrees with mode");
  AST_FORCE_ENTRY: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (mode == DCS_RUN) && permit && bkpt_en && force_sel && bp.force_pending && cpu_instr_boundary
    |=> active ##1 !bp.force_pending)
    else $error("forced breakpoint did not enter background");
  AST_BGND_WAKE: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (mode == DCS_RUN) && permit && is_bgnd && cpu_wait_stop |=> active && cpu_wake ##1 !cpu_wake)
    else $error("background command did not leave wait/stop");
  AST_READ_STATUS: assert property (@(posedge ref_clk) disable iff (!reset_n)
    is_rd_status |=> rsp_valid && rsp_data[SC_W-1:0] == $past(status_byte) && rsp_data[BIT_DVF] == 1'b0)
    else $error("status read returned wrong byte");
  AST_STATUS_READ_ONLY: assert property (@(posedge ref_clk) disable iff (!reset_n)
    is_wr_ctrl && !is_bgnd && !cpu_wait_stop && !mem_cmd_fail_ws && !enter_bgnd
    |=> st.wait_stop_fail == $past(st.wait_stop_fail) && active == $past(active))
    else $error("write-control changed a status bit");

  // command port checks
  AST_RSP_ONLY_ON_READ: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !is_rd_status && !is_rd_bkpt |=> !rsp_valid)
    else $error("answer given without a read command");
  AST_RSP_UPPER_ZERO: assert property (@(posedge ref_clk) disable iff (!reset_n)
    is_rd_status |=> rsp_data[BP_W-1:SC_W] == '0)
    else $error("status answer upper byte not zero");
  AST_READ_BKPT: assert property (@(posedge ref_clk) disable iff (!reset_n)
    is_rd_bkpt |=> rsp_valid && rsp_data == $past(bp.match_addr))
    else $error("match address read returned wrong value");
  AST_WRITE_BKPT: assert property (@(posedge ref_clk) disable iff (!reset_n)
    is_wr_bkpt |=> bp.match_addr == $past(cmd_wdata))
    else $error("match address write lost");
  AST_BKPT_ONLY_BY_CMD: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !is_wr_bkpt |=> bp.match_addr == $past(bp.match_addr))
    else $error("match address changed without a command");
  AST_CTRL_ONLY_BY_CMD: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !is_wr_ctrl |=> permit == $past(permit) && bkpt_en == $past(bkpt_en) &&
    force_sel == $past(force_sel) && clk_sel == $past(clk_sel))
    else $error("control bit changed without a command");
  AST_PERMIT_WRITE: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (mode == DCS_RUN) && is_wr_ctrl |=> permit == $past(cmd_wdata[BIT_PERMIT]))
    else $error("permit write lost while user code runs");
  AST_BKPT_CTRL_WRITE: assert property (@(posedge ref_clk) disable iff (!reset_n)
    is_wr_ctrl |=> bkpt_en == $past(cmd_wdata[BIT_BKPT_EN]) && force_sel == $past(cmd_wdata[BIT_FORCE]))
    else $error("breakpoint control write lost");

  // background mode checks
  AST_GO_LEAVES: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (mode == DCS_BGND) && is_go |=> !active)
    else $error("go command did not leave background");
  AST_BGND_STAYS: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (mode == DCS_BGND) && !is_go |=> active)
    else $error("background left without a go command");
  AST_BGND_ENTRY: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (mode == DCS_RUN) && permit && is_bgnd |=> active)
    else $error("background command ignored although permitted");
  AST_TAG_ENTRY: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (mode == DCS_RUN) && permit && bkpt_en && !force_sel && cpu_tag_at_queue_end |=> active)
    else $error("tagged opcode at queue end did not enter background");
  AST_NO_BKPT_ENTRY: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (mode == DCS_RUN) && !bkpt_en && !is_bgnd |=> !active)
    else $error("background entered by a disabled breakpoint");
  AST_WAKE_ONLY: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !(enter_bgnd && is_bgnd && cpu_wait_stop) |=> !cpu_wake)
    else $error("wake pulse without background command in wait/stop");
  AST_WS_AFTER_WAKE: assert property (@(posedge ref_clk) disable iff (!reset_n)
    st.enter_from_ws |=> wait_stop_status)
    else $error("wait/stop status lost on entry from wait/stop");
  AST_WSF_CLEAR: assert property (@(posedge ref_clk) disable iff (!reset_n)
    is_bgnd && !mem_cmd_fail_ws |=> !st.wait_stop_fail)
    else $error("failure flag not cleared by background command");
endmodule : dcs_regs
`default_nettype wire

// file: dcs_status.sv
// wait/stop status flags of the debug controller
`timescale 1ns/1ns
`default_nettype none
module dcs_status (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // control side
  dcs_st_if.unit   st
);
  import dcs_pkg::*;

  logic ws;
  logic wait_stop_fail;
  logic next_ws;
  logic next_wsf;

  always_comb begin
    // stays set while background was entered out of wait or stop
    next_ws  = st.cpu_wait_stop || st.enter_from_ws || (ws && st.active);
    // a new failure wins over a clear in the same cycle
    next_wsf = st.fail || (wait_stop_fail && !st.clear_fail);
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ws  <= 1'b0;
      wait_stop_fail <= 1'b0;
    end else begin
      ws  <= next_ws;
      wait_stop_fail <= next_wsf;
    end
  end

  assign st.ws  = ws;
  assign st.wait_stop_fail = wait_stop_fail;

  AST_WS_FOLLOWS: assert property (@(posedge ref_clk) disable iff (!reset_n)
    st.cpu_wait_stop |=> ws)
    else $error("wait/stop status not set");
  AST_WS_CLEARS: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !st.cpu_wait_stop && !st.enter_from_ws && !st.active |=> !ws)
    else $error("wait/stop status stuck");
  AST_WSF_SET: assert property (@(posedge ref_clk) disable iff (!reset_n)
    st.fail |=> wait_stop_fail [*2] or (wait_stop_fail ##1 (st.fail || !wait_stop_fail)))
    else $error("wait/stop failure flag not set");
endmodule : dcs_status
`default_nettype wire

// file: debug_ctrl_status_regs_tb_top.sv
// self-checking bench for the debug status/control registers
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin err_count++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, ex, gt); end end
module debug_ctrl_status_regs_tb_top;
  import dcs_pkg::*;
  logic        ref_clk = 1'b0;
  logic        reset_n, cmd_valid, rsp_valid;
  logic [7:0]  cmd_code, d;
  logic [15:0] cmd_wdata, rsp_data, cpu_addr, a;
  logic        cpu_addr_valid, cpu_opcode_fetch, cpu_instr_boundary, cpu_tag_at_queue_end;
  logic        cpu_wait_stop, mem_cmd_fail_ws, background_active, cpu_wake, tag_opcode;
  logic        background_permit, comm_clock_select, wait_stop_status;
  logic [16:0] ans;
  logic [7:0]  go_codes [3] = '{CMD_GO, CMD_TRACE1, CMD_TAGGO};
  logic [7:0]  dis_ctl [2] = '{8'h80, 8'h90};
  int          err_count, compares;

  always #4 ref_clk = ~ref_clk;

  dcs_host_model host (.ref_clk(ref_clk), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));

  dcs_regs DUT (.ref_clk(ref_clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .cpu_addr(cpu_addr),
    .cpu_addr_valid(cpu_addr_valid), .cpu_opcode_fetch(cpu_opcode_fetch),
    .cpu_instr_boundary(cpu_instr_boundary), .cpu_tag_at_queue_end(cpu_tag_at_queue_end),
    .cpu_wait_stop(cpu_wait_stop), .mem_cmd_fail_ws(mem_cmd_fail_ws),
    .background_active(background_active), .cpu_wake(cpu_wake), .tag_opcode(tag_opcode),
    .background_permit(background_permit), .comm_clock_select(comm_clock_select),
    .wait_stop_status(wait_stop_status));

  // expected read-status answer; dvf always reads 0
  function automatic logic [16:0] exp_sc(logic [7:0] ctl, logic act, logic ws, logic wait_stop_fail);
    return {1'b1, 8'h00, ctl[7], act, ctl[5:3], ws, wait_stop_fail, 1'b0};
  endfunction : exp_sc

  task automatic chk_sc(input logic [7:0] ctl, input logic act, input logic ws, input logic wait_stop_fail);
    host.read(CMD_READ_STATUS, ans);
    `CHK("status", exp_sc(ctl, act, ws, wait_stop_fail), ans)
  endtask : chk_sc

  // cpu access to the match address, then an instruction boundary two cycles later
  task automatic cpu_hit(input logic fetch, input logic exp_tag);
    @(posedge ref_clk);
    cpu_addr         <= 16'h1234;
    cpu_addr_valid   <= 1'b1;
    cpu_opcode_fetch <= fetch;
    @(posedge ref_clk);
    cpu_addr_valid   <= 1'b0;
    cpu_opcode_fetch <= 1'b0;
    cpu_addr         <= 16'(~$urandom);
    @(posedge ref_clk);
    `CHK("tag", exp_tag, tag_opcode)
    `CHK("early active", 1'b0, background_active)
    cpu_instr_boundary <= 1'b1;
    @(posedge ref_clk);
    cpu_instr_boundary <= 1'b0;
  endtask : cpu_hit

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    wrap_up();
  end

  initial begin
    {reset_n, cpu_addr_valid, cpu_opcode_fetch, cpu_instr_boundary} = '0;
    {cpu_tag_at_queue_end, cpu_wait_stop, mem_cmd_fail_ws} = '0;
    cpu_addr  = 16'h0000;
    err_count = 0;
    compares  = 0;
    void'($urandom(90136));
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    chk_sc(8'h00, 0, 0, 0);
    host.read(CMD_READ_BKPT, ans);
    `CHK("bkpt reset", 17'h10000, ans)
    // random control bytes and match addresses while the user program runs
    repeat (8) begin
      d = 8'($urandom);
      a = 16'($urandom);
      host.write_ctl(d, $urandom_range(2));
      chk_sc(d, 0, 0, 0);
      `CHK("clksel", d[3], comm_clock_select)
      `CHK("permit", d[7], background_permit)
      host.send(CMD_WRITE_BKPT, a, $urandom_range(2));
      host.read(CMD_READ_BKPT, ans);
      `CHK("bkpt", {1'b1, a}, ans)
    end
    host.write_ctl(8'h00, 0);
    host.enter_bg(ans);
    `CHK("bg refused", exp_sc(8'h00, 0, 0, 0), ans)
    host.write_ctl(8'h80, 0);
    host.enter_bg(ans);
    `CHK("bg entered", exp_sc(8'h80, 1, 0, 0), ans)
    host.write_ctl(8'h08, 0);
    chk_sc(8'h88, 1, 0, 0);
    foreach (go_codes[i]) begin
      host.send(go_codes[i], 16'h0000, 0);
      chk_sc(8'h88, 0, 0, 0);
      host.enter_bg(ans);
      `CHK("bg again", exp_sc(8'h88, 1, 0, 0), ans)
    end
    host.send(CMD_GO, 16'h0000, 0);
    // background command pulls the cpu out of wait/stop
    cpu_wait_stop <= 1'b1;
    chk_sc(8'h88, 0, 1, 0);
    `CHK("ws out", 1'b1, wait_stop_status)
    host.send(CMD_BACKGROUND, 16'h0000, 0);
    @(posedge ref_clk);
    `CHK("wake", 1'b1, cpu_wake)
    `CHK("active", 1'b1, background_active)
    cpu_wait_stop <= 1'b0;
    chk_sc(8'h88, 1, 1, 0);
    host.send(CMD_GO, 16'h0000, 0);
    chk_sc(8'h88, 0, 0, 0);
    // memory command failure, then recovery through background
    mem_cmd_fail_ws <= 1'b1;
    @(posedge ref_clk);
    mem_cmd_fail_ws <= 1'b0;
    chk_sc(8'h88, 0, 0, 1);
    host.enter_bg(ans);
    `CHK("wsf cleared", exp_sc(8'h88, 1, 0, 0), ans)
    host.send(CMD_GO, 16'h0000, 0);
    // breakpoint disabled, forced and tagged
    host.send(CMD_WRITE_BKPT, 16'h1234, 0);
    foreach (dis_ctl[i]) begin
      host.write_ctl(dis_ctl[i], 0);
      cpu_hit(1'b1, 1'b0);
      chk_sc(dis_ctl[i], 0, 0, 0);
    end
    host.write_ctl(8'hB0, 0);
    cpu_hit(1'b0, 1'b0);
    chk_sc(8'hB0, 1, 0, 0);
    host.send(CMD_GO, 16'h0000, 0);
    host.write_ctl(8'hA0, 0);
    cpu_hit(1'b1, 1'b1);
    chk_sc(8'hA0, 0, 0, 0);
    @(posedge ref_clk);
    cpu_tag_at_queue_end <= 1'b1;
    @(posedge ref_clk);
    cpu_tag_at_queue_end <= 1'b0;
    chk_sc(8'hA0, 1, 0, 0);
    // reset in mid-session clears the controls
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    chk_sc(8'h00, 0, 0, 0);
    wrap_up();
  end
endmodule : debug_ctrl_status_regs_tb_top
`default_nettype wire
